/* rtl/mqaf_cfg.svh */
// Constants for the multi-queue active flag block: sizes, field positions, resets.
// Assumes inclusion by bare name from the package and design files.
`ifndef MQAF_CFG_SVH
`define MQAF_CFG_SVH

`define MQAF_DATA_W    36
`define MQAF_NQ        16
`define MQAF_QW        4
`define MQAF_ADDR_W    7
`define MQAF_CHIP_W    3
`define MQAF_CHIP_LSB  4
`define MQAF_PTR_W     8
`define MQAF_CNT_W     9
`define MQAF_DEPTH     9'h100
`define MQAF_OFF_DEF_A 9'h008
`define MQAF_OFF_DEF_B 9'h080
`define MQAF_FBUS_W    8
`define MQAF_FBUS_SELW 3
`define MQAF_BUF_CNT_W 2
`define MQAF_BUF_FULL  2'h2
`define MQAF_FLAG_RST  1'h1

`endif

/* rtl/mqaf_pkg.sv */
// Types and shared decode functions for the multi-queue active flag block.
// Assumes mqaf_cfg.svh is on the include path.
`include "mqaf_cfg.svh"

package mqaf_pkg;

  typedef logic [`MQAF_DATA_W-1:0] mqaf_data_t;
  typedef logic [`MQAF_ADDR_W-1:0] mqaf_addr_t;
  typedef logic [`MQAF_QW-1:0]     mqaf_qidx_t;
  typedef logic [`MQAF_CHIP_W-1:0] mqaf_chip_t;
  typedef logic [`MQAF_CNT_W-1:0]  mqaf_cnt_t;
  typedef logic [`MQAF_PTR_W-1:0]  mqaf_ptr_t;
  typedef logic [`MQAF_FBUS_W-1:0] mqaf_fbus_t;

  typedef enum logic [1:0] {
    RSW_IDLE,
    RSW_WAIT,
    RSW_LOAD
  } mqaf_rsw_t;

  // Device select field of a queue address against the strapped chip code
  function automatic logic mqaf_chip_hit(mqaf_addr_t sel, mqaf_chip_t code);
    mqaf_chip_hit = (sel[`MQAF_ADDR_W-1:`MQAF_CHIP_LSB] == code);
  endfunction

  // Almost full once free space is at or below the offset
  function automatic logic mqaf_is_af(mqaf_cnt_t cnt, mqaf_cnt_t off);
    mqaf_is_af = (cnt >= (`MQAF_DEPTH - off));
  endfunction

endpackage

/* rtl/mqaf_buf.sv */
// Two-entry buffer between the write port and the queue memory.
// Assumes the drain side may stall for any number of cycles.
module mqaf_buf
  import mqaf_pkg::*;
(
  input  wire                 clk,
  input  wire                 sys_rst,
  input  mqaf_pkg::mqaf_data_t in_data,
  input  wire                 in_valid,
  output logic                in_ready,
  output mqaf_pkg::mqaf_data_t out_data,
  output logic                out_valid,
  input  wire                 out_ready
);

  mqaf_data_t                 slot [2];
  mqaf_data_t                 next_slot [2];
  logic                       head;
  logic                       next_head;
  logic [`MQAF_BUF_CNT_W-1:0] cnt;
  logic [`MQAF_BUF_CNT_W-1:0] next_cnt;
  logic                       next_in_ready;
  logic                       push;
  logic                       pop;

  assign out_valid = (cnt != '0);
  assign out_data  = slot[head];

  always_comb begin
    push          = in_valid && in_ready;
    pop           = out_valid && out_ready;
    next_slot     = slot;
    next_head     = head ^ pop;
    next_cnt      = cnt;
    if (push) begin
      next_slot[head ^ cnt[0]] = in_data;
    end
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
    // Ready is registered so a stalled drain never lets a third word in
    next_in_ready = (next_cnt != `MQAF_BUF_FULL);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot[0]  <= '0;
      slot[1]  <= '0;
      head     <= 1'b0;
      cnt      <= '0;
      in_ready <= 1'b0;
    end else begin
      slot     <= next_slot;
      head     <= next_head;
      cnt      <= next_cnt;
      in_ready <= next_in_ready;
    end
  end

endmodule

/* rtl/mqaf_top.sv */
// Multi-queue store with active-queue output valid and almost-full flags.
// Assumes one clock for both ports and a controller that keeps the
// select and enable inputs synchronous to it.
module mqaf_top
  import mqaf_pkg::*;
(
  input  wire                  clk,
  input  wire                  sys_rst,
  input  wire                  chip_code_bit0,
  input  wire                  chip_code_bit1,
  input  wire                  chip_code_bit2,
  input  wire                  default_offset_sel,
  input  wire                  offset_load,
  input  mqaf_pkg::mqaf_qidx_t offset_queue,
  input  mqaf_pkg::mqaf_cnt_t  offset_value,
  input  mqaf_pkg::mqaf_addr_t write_queue_select_bus,
  input  wire                  write_select_enable,
  input  mqaf_pkg::mqaf_data_t write_data,
  input  wire                  write_valid,
  output logic                 write_ready,
  input  mqaf_pkg::mqaf_addr_t read_queue_select_bus,
  input  wire                  read_select_enable,
  input  wire                  read_enable_n,
  output mqaf_pkg::mqaf_data_t read_data,
  output logic                 output_valid_flag_n,
  output logic                 output_valid_flag_oe_n,
  output logic                 almost_full_flag_n,
  output mqaf_pkg::mqaf_fbus_t almost_full_bus_n
);

  mqaf_chip_t  chip_code;
  mqaf_data_t  buf_data;
  logic        buf_valid;
  logic        drain_ready;

  // Queue storage and bookkeeping
  mqaf_data_t  mem [`MQAF_NQ][1 << `MQAF_PTR_W];
  mqaf_cnt_t   cnt [`MQAF_NQ];
  mqaf_cnt_t   next_cnt [`MQAF_NQ];
  mqaf_ptr_t   wptr [`MQAF_NQ];
  mqaf_ptr_t   next_wptr [`MQAF_NQ];
  mqaf_ptr_t   rptr [`MQAF_NQ];
  mqaf_ptr_t   next_rptr [`MQAF_NQ];
  mqaf_cnt_t   off [`MQAF_NQ];
  mqaf_cnt_t   next_off [`MQAF_NQ];
  logic        dflt_pend;
  logic        next_dflt_pend;

  // Write port selection
  mqaf_addr_t  wsel;
  mqaf_addr_t  next_wsel;
  logic        wsw_hold;
  logic        next_wsw_hold;
  mqaf_qidx_t  wq;
  logic        w_hit;
  logic        do_wr;

  // Read port selection and output register
  mqaf_addr_t  rsel;
  mqaf_addr_t  next_rsel;
  mqaf_addr_t  rnew;
  mqaf_addr_t  next_rnew;
  mqaf_rsw_t   rsw;
  mqaf_rsw_t   next_rsw;
  mqaf_qidx_t  rq;
  logic        r_hit;
  logic        load_req;
  logic        do_rd;
  mqaf_data_t  next_read_data;
  logic        next_ov_n;
  logic        next_ov_oe_n;

  // Almost-full pipeline
  logic        af_stage_n;
  logic        next_af_stage_n;
  mqaf_fbus_t  fbus_stage_n;
  mqaf_fbus_t  next_fbus_stage_n;

  assign chip_code = {chip_code_bit2, chip_code_bit1, chip_code_bit0};

  mqaf_buf u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (write_data),
    .in_valid  (write_valid),
    .in_ready  (write_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (drain_ready)
  );

  // ---------------- Write side ----------------
  always_comb begin
    wq            = wsel[`MQAF_QW-1:0];
    w_hit         = mqaf_chip_hit(wsel, chip_code);
    next_wsel     = wsel;
    next_wsw_hold = 1'b0;
    if (write_select_enable) begin
      next_wsel     = write_queue_select_bus;
      next_wsw_hold = 1'b1;
    end
    // Words for another device are taken and dropped so the buffer never jams;
    // a full local queue stalls the buffer instead of losing the word.
    drain_ready = !wsw_hold && (!w_hit || (cnt[wq] != `MQAF_DEPTH));
    do_wr       = buf_valid && drain_ready && w_hit;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wsel     <= '0;
      wsw_hold <= 1'b0;
    end else begin
      wsel     <= next_wsel;
      wsw_hold <= next_wsw_hold;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wq][wptr[wq]] <= buf_data;
    end
  end

  // ---------------- Read side ----------------
  always_comb begin
    rq        = rsel[`MQAF_QW-1:0];
    r_hit     = mqaf_chip_hit(rsel, chip_code);
    next_rsel = rsel;
    next_rnew = rnew;
    next_rsw  = rsw;
    unique case (rsw)
      RSW_IDLE: begin
      end
      RSW_WAIT: begin
        // Old queue keeps serving this cycle; the switch lands next edge
        next_rsel = rnew;
        next_rsw  = RSW_LOAD;
      end
      RSW_LOAD: begin
        next_rsw = RSW_IDLE;
      end
    endcase
    if (read_select_enable) begin
      next_rnew = read_queue_select_bus;
      next_rsw  = RSW_WAIT;
    end
  end

  always_comb begin
    // Empty output register or an enabled read asks for the next word
    load_req       = (rsw == RSW_LOAD) || output_valid_flag_n || !read_enable_n;
    do_rd          = r_hit && load_req && (cnt[rq] != '0);
    next_read_data = read_data;
    next_ov_n      = output_valid_flag_n;
    next_ov_oe_n   = output_valid_flag_oe_n;
    if (do_rd) begin
      next_read_data = mem[rq][rptr[rq]];
    end
    if (!r_hit) begin
      next_ov_n = 1'b1;
    end else if (load_req) begin
      next_ov_n = !do_rd;
    end
    if (rsw == RSW_LOAD) begin
      // Bus ownership moves with the first word of the new queue
      next_ov_oe_n = !r_hit;
    end
    // A strapped code of zero matches the reset selection, so never show valid while floating
    if (next_ov_oe_n) begin
      next_ov_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsel                   <= '0;
      rnew                   <= '0;
      rsw                    <= RSW_IDLE;
      read_data              <= '0;
      output_valid_flag_n    <= `MQAF_FLAG_RST;
      output_valid_flag_oe_n <= 1'b1;
    end else begin
      rsel                   <= next_rsel;
      rnew                   <= next_rnew;
      rsw                    <= next_rsw;
      read_data              <= next_read_data;
      output_valid_flag_n    <= next_ov_n;
      output_valid_flag_oe_n <= next_ov_oe_n;
    end
  end

  // ---------------- Per-queue counts and pointers ----------------
  always_comb begin
    for (int q = 0; q < `MQAF_NQ; q++) begin
      next_cnt[q]  = cnt[q];
      next_wptr[q] = wptr[q];
      next_rptr[q] = rptr[q];
      if (do_wr && (wq == q[`MQAF_QW-1:0])) begin
        next_wptr[q] = wptr[q] + 8'h01;
      end
      if (do_rd && (rq == q[`MQAF_QW-1:0])) begin
        next_rptr[q] = rptr[q] + 8'h01;
      end
      // Every queue tracks its level whether or not it is visible
      if ((next_wptr[q] != wptr[q]) && (next_rptr[q] == rptr[q])) begin
        next_cnt[q] = cnt[q] + 9'h001;
      end else if ((next_wptr[q] == wptr[q]) && (next_rptr[q] != rptr[q])) begin
        next_cnt[q] = cnt[q] - 9'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int q = 0; q < `MQAF_NQ; q++) begin
        cnt[q]  <= '0;
        wptr[q] <= '0;
        rptr[q] <= '0;
      end
    end else begin
      cnt  <= next_cnt;
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // ---------------- Almost-full offsets ----------------
  always_comb begin
    next_off       = off;
    next_dflt_pend = 1'b0;
    if (dflt_pend) begin
      // Strap is sampled on the first edge after reset release
      for (int q = 0; q < `MQAF_NQ; q++) begin
        next_off[q] = default_offset_sel ? `MQAF_OFF_DEF_B : `MQAF_OFF_DEF_A;
      end
    end else if (offset_load) begin
      // Offsets past the depth would wrap the compare, so they saturate
      next_off[offset_queue] = (offset_value > `MQAF_DEPTH) ? `MQAF_DEPTH : offset_value;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dflt_pend <= 1'b1;
      for (int q = 0; q < `MQAF_NQ; q++) begin
        off[q] <= `MQAF_OFF_DEF_A;
      end
    end else begin
      dflt_pend <= next_dflt_pend;
      off       <= next_off;
    end
  end

  // ---------------- Almost-full flag, two register stages ----------------
  always_comb begin
    // First stage samples the level of the queue that is selected now
    next_af_stage_n = !(w_hit && mqaf_is_af(cnt[wq], off[wq]));
    for (int i = 0; i < `MQAF_FBUS_W; i++) begin
      next_fbus_stage_n[i] = !(w_hit && mqaf_is_af(cnt[{wq[`MQAF_QW-1], i[`MQAF_FBUS_SELW-1:0]}],
                                                   off[{wq[`MQAF_QW-1], i[`MQAF_FBUS_SELW-1:0]}]));
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      af_stage_n         <= `MQAF_FLAG_RST;
      fbus_stage_n       <= '1;
      almost_full_flag_n <= `MQAF_FLAG_RST;
      almost_full_bus_n  <= '1;
    end else begin
      af_stage_n         <= next_af_stage_n;
      fbus_stage_n       <= next_fbus_stage_n;
      almost_full_flag_n <= af_stage_n;
      almost_full_bus_n  <= fbus_stage_n;
    end
  end

endmodule

/* dv/mqaf_props.sv */
// Checker for the active flag block: switch timing, float control, almost-full cause.
// Assumes it is bound to mqaf_top and sees only that module's ports.
module mqaf_props
  import mqaf_pkg::*;
(
  input wire clk,
  input wire sys_rst,
  input wire chip_code_bit0,
  input wire chip_code_bit1,
  input wire chip_code_bit2,
  input wire offset_load,
  input mqaf_pkg::mqaf_addr_t write_queue_select_bus,
  input wire write_select_enable,
  input wire write_valid,
  input wire write_ready,
  input mqaf_pkg::mqaf_addr_t read_queue_select_bus,
  input wire read_select_enable,
  input wire read_enable_n,
  input mqaf_pkg::mqaf_data_t read_data,
  input wire output_valid_flag_n,
  input wire output_valid_flag_oe_n,
  input wire almost_full_flag_n,
  input mqaf_pkg::mqaf_fbus_t almost_full_bus_n
);
  logic [2:0] rsh;
  logic [2:0] wsh;
  logic [7:0] wth;
  mqaf_addr_t rq;
  mqaf_addr_t wq;
  logic [2:0] code;
  assign code = {chip_code_bit2, chip_code_bit1, chip_code_bit0};
  // Select and write history ties each flag change to the edge that caused it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsh <= 3'h0;
      wsh <= 3'h0;
      wth <= 8'h00;
      rq <= 7'h00;
      wq <= 7'h00;
    end else begin
      rsh <= {rsh[1:0], read_select_enable};
      wsh <= {wsh[1:0], write_select_enable};
      wth <= {wth[6:0], (write_valid & write_ready) | offset_load};
      if (read_select_enable) rq <= read_queue_select_bus;
      if (write_select_enable) wq <= write_queue_select_bus;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property ($past(sys_rst) |-> output_valid_flag_n && output_valid_flag_oe_n
    && almost_full_flag_n && almost_full_bus_n == 8'hFF && !write_ready) else $error("Flags not idle after reset");
  a_oe_on_switch: assert property (rsh == 3'h4 |-> output_valid_flag_oe_n == (rq[6:4] != code))
    else $error("Flag drive wrong after read select");
  a_oe_only_switch: assert property ($changed(output_valid_flag_oe_n) |-> rsh[2])
    else $error("Flag drive changed off the switch edge");
  a_ov_float: assert property (output_valid_flag_oe_n |-> output_valid_flag_n)
    else $error("Valid shown while not driving");
  a_ov_hold: assert property (!output_valid_flag_n && read_enable_n && rsh[1:0] == 2'h0
    |=> $stable(read_data) && !output_valid_flag_n) else $error("Output word moved without a read");
  a_af_bus_dup: assert property (wsh[1:0] == 2'h0 |-> almost_full_bus_n[wq[2:0]] == almost_full_flag_n)
    else $error("Flag bus bit differs from almost-full flag");
  a_af_other_dev: assert property (wsh == 3'h4 && wq[6:4] != code |-> almost_full_flag_n
    && almost_full_bus_n == 8'hFF) else $error("Almost-full active for another device");
  a_af_fall_cause: assert property ($fell(almost_full_flag_n) |-> wsh[2] || (|wth[7:3]))
    else $error("Almost-full fell without a cause in time");
  cover property (rsh == 3'h4 && !output_valid_flag_n);
  cover property ($fell(almost_full_flag_n));
  cover property (!write_ready);
endmodule

bind mqaf_top mqaf_props u_props (.*);

/* dv/mqaf_ctrl_model.sv */
// Write-side controller model: offers a run of counted words, a gap after each when slow.
// Assumes write_ready is a registered level from the block.
module mqaf_ctrl_model
  import mqaf_pkg::*;
(
  input wire clk,
  input wire sys_rst,
  input wire start,
  input mqaf_pkg::mqaf_cnt_t count,
  input mqaf_pkg::mqaf_data_t base,
  input wire slow,
  input wire write_ready,
  output logic write_valid,
  output mqaf_pkg::mqaf_data_t write_data,
  output logic done
);
  mqaf_cnt_t left;
  mqaf_data_t word;
  logic gap;
  assign write_valid = (left != 9'h0) && !gap;
  // Idle data is inverted so a stale word never passes for a new one
  assign write_data = write_valid ? word : ~word;
  assign done = (left == 9'h0);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 9'h0;
      word <= 36'h0;
      gap <= 1'b0;
    end else if (start) begin
      left <= count;
      word <= base;
    end else begin
      gap <= write_valid & write_ready & slow;
      if (write_valid & write_ready) begin
        left <= left - 9'h1;
        word <= word + 36'h1;
      end
    end
  end
endmodule

/* dv/multiqueue_active_flags_test.sv */
// Bench for the active flag block: read switching, float control, almost-full timing, buffer stall.
// Assumes mqaf_ctrl_model drives the write port and mqaf_props is bound to the design.
module multiqueue_active_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mqaf_pkg::*;
  localparam mqaf_addr_t loc = 7'h20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b0;
  logic ol = 1'b0;
  logic wse = 1'b0;
  logic rse = 1'b0;
  logic ren_n = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  mqaf_cnt_t cnt = 9'h0;
  mqaf_cnt_t oval = 9'h0;
  mqaf_qidx_t oq = 4'h0;
  mqaf_addr_t wa = 7'h0;
  mqaf_addr_t ra = 7'h0;
  mqaf_data_t base = 36'h0;
  mqaf_data_t wd;
  mqaf_data_t rd;
  mqaf_fbus_t afb;
  logic wv, wr, ovf, oe, af, done;
  int num_errors = 0;
  int compares = 0;
  always #2 clk = ~clk;
  mqaf_top dut (.clk, .sys_rst, .chip_code_bit0(1'b0), .chip_code_bit1(1'b1), .chip_code_bit2(1'b0),
    .default_offset_sel(strap), .offset_load(ol), .offset_queue(oq), .offset_value(oval),
    .write_queue_select_bus(wa), .write_select_enable(wse), .write_data(wd), .write_valid(wv), .write_ready(wr),
    .read_queue_select_bus(ra), .read_select_enable(rse), .read_enable_n(ren_n), .read_data(rd),
    .output_valid_flag_n(ovf), .output_valid_flag_oe_n(oe), .almost_full_flag_n(af), .almost_full_bus_n(afb));
  mqaf_ctrl_model ctrl (.clk, .sys_rst, .start, .count(cnt), .base, .slow, .write_ready(wr),
    .write_valid(wv), .write_data(wd), .done);
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wsel(input mqaf_addr_t a);
    wa = a;
    wse = 1'b1;
    tick(1);
    wse = 1'b0;
  endtask
  task automatic rsel(input mqaf_addr_t a);
    ra = a;
    rse = 1'b1;
    tick(1);
    rse = 1'b0;
  endtask
  task automatic rdn(input int n);
    ren_n = 1'b0;
    tick(n);
    ren_n = 1'b1;
  endtask
  task automatic go(input mqaf_cnt_t n, input mqaf_data_t b);
    cnt = n;
    base = b;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask
  task automatic wr_run(input mqaf_cnt_t n, input mqaf_data_t b);
    go(n, b);
    for (int i = 0; i < 600 && !done; i++) tick(1);
  endtask
  task automatic do_reset(input logic s);
    strap = s;
    sys_rst = 1'b1;
    tick(4);
    sys_rst = 1'b0;
    tick(2);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    chk("ov", ovf, 1'b1);
    chk("afbus", afb, 8'hFF);
    chk("af", af, 1'b1);
    chk("oe", oe, 1'b1);
    wsel(loc);
    rsel(loc | 7'h1);
    wr_run(9'h3, 36'h100);
    tick(4);
    chk("ov", ovf, 1'b1);
    rsel(loc);
    tick(1);
    chk("ov", ovf, 1'b1);
    tick(1);
    chk("ov", ovf, 1'b0);
    chk("rdata", rd, 36'h100);
    chk("oe", oe, 1'b0);
    tick(2);
    rsel(loc | 7'h1);
    tick(1);
    chk("rdata", rd, 36'h100);
    tick(1);
    chk("ov", ovf, 1'b1);
    rsel(loc);
    tick(2);
    chk("rdata", rd, 36'h101);
    rdn(1);
    chk("rdata", rd, 36'h102);
    tick(1);
    chk("ov", ovf, 1'b0);
    rdn(1);
    chk("ov", ovf, 1'b1);
    rsel(7'h30);
    tick(2);
    chk("oe", oe, 1'b1);
    slow = 1'b1;
    wr_run(9'hF7, 36'h1000);
    slow = 1'b0;
    tick(4);
    chk("af", af, 1'b1);
    wr_run(9'h1, 36'h2000);
    tick(2);
    chk("af", af, 1'b1);
    tick(1);
    chk("af", af, 1'b0);
    chk("afbus", afb, 8'hFE);
    wsel(loc | 7'h1);
    tick(1);
    chk("af", af, 1'b0);
    tick(1);
    chk("af", af, 1'b1);
    rsel(loc);
    tick(5);
    chk("afbus", afb, 8'hFF);
    wsel(loc);
    tick(2);
    chk("af", af, 1'b1);
    wr_run(9'h1, 36'h3000);
    tick(4);
    rdn(1);
    tick(1);
    chk("af", af, 1'b0);
    tick(1);
    chk("af", af, 1'b1);
    chk("rdata", rd, 36'h1001);
    go(9'hC, 36'h4000);
    tick(20);
    chk("wready", wr, 1'b0);
    rdn(300);
    tick(2);
    chk("ov", ovf, 1'b1);
    chk("done", done, 1'b1);
    oq = 4'h2;
    oval = 9'h100;
    ol = 1'b1;
    tick(1);
    ol = 1'b0;
    wsel(loc | 7'h2);
    tick(2);
    chk("af", af, 1'b0);
    wsel(7'h50);
    tick(2);
    chk("afbus", afb, 8'hFF);
    do_reset(1'b1);
    wsel(loc);
    wr_run(9'h7F, 36'h0);
    tick(4);
    chk("af", af, 1'b1);
    wr_run(9'h1, 36'h0);
    tick(4);
    chk("af", af, 1'b0);
    complete_run;
  end
  initial begin
    #80000;
    num_errors++;
    complete_run;
  end
endmodule
